// *** rtl/wit_watch_timer.v ***
// Purpose: Watch timer with 11-bit prescaler, 5-bit counter, two events
// Assumes: Oscillator ticks are one-cycle enables synchronous to i_ref_clk
// Notes: Watch clock is a tick enable, never a derived clock
`timescale 1ns/1ps
`default_nettype none
`include "wit_defines.vh"

// Operation
// - Clock select: main div 128 or sub
// - 11-bit prescaler feeding one 5-bit counter
// - Interval code n gives 2^(n+4) cycles
// - Period codes: 2^14, 2^13, 2^5, 2^4
// - Run bit starts counter; zero stops, clears
// - Enable zero clears prescaler and counter
// - Watch event needs enable and run
// - Interval event runs whenever enabled
// - Run clear restarts counter, prescaler keeps going
// - Counter starts after one counter tap period (bit 8, 2^9 cycles)
// - Mode resets zero; bit and byte writes
module wit_watch_timer
#(
  parameter PRE_W = `WIT_PRE_W,
  parameter CNT_W = `WIT_CNT_W,
  parameter MAIN_DIV_W = `WIT_MAIN_DIV_W
)
(
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Oscillator tick enables
  input wire i_main_osc_tick,
  input wire i_sub_osc_tick,
  // Register port
  input wire [`WIT_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Events and interrupt
  output reg o_periodic_watch_irq,
  output reg o_interval_irq,
  output wire o_irq
);

  //--------------------------------------------------------------
  // Local constants
  //--------------------------------------------------------------
  localparam [1:0] PER_LONG = 2'h0;
  localparam [1:0] PER_MID = 2'h1;
  localparam [1:0] PER_SHORT = 2'h2;
  localparam [1:0] PER_TINY = 2'h3;
  localparam N_EVT = 2;

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  reg [7:0] watch_mode_control_q;
  reg [7:0] watch_mode_control_d;
  reg [N_EVT-1:0] stat_q;
  reg [N_EVT-1:0] mask_q;
  reg [N_EVT-1:0] mask_d;
  reg [MAIN_DIV_W-1:0] div_q;
  reg [MAIN_DIV_W-1:0] div_d;
  reg [PRE_W-1:0] pre_q;
  reg [PRE_W-1:0] pre_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg armed_q;
  reg armed_d;
  reg [7:0] rdata_d;
  reg watch_evt;

  //--------------------------------------------------------------
  // Mode fields
  //--------------------------------------------------------------
  wire timer_enable = watch_mode_control_q[`WIT_BIT_EN];
  wire counter_run = watch_mode_control_q[`WIT_BIT_RUN];
  wire clock_source_sel = watch_mode_control_q[`WIT_BIT_CLK];
  wire [2:0] interval_sel =
    watch_mode_control_q[`WIT_BIT_IVL2:`WIT_BIT_IVL0];
  wire [1:0] period_sel =
    watch_mode_control_q[`WIT_BIT_PER1:`WIT_BIT_PER0];

  //--------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------
  wire hit_mode = (i_addr == `WIT_MODE_OFS);
  wire hit_stat = (i_addr == `WIT_STAT_OFS);
  wire hit_mask = (i_addr == `WIT_MASK_OFS);
  wire wr_mode = i_wr && hit_mode;
  wire wr_stat = i_wr && hit_stat;
  wire wr_mask = i_wr && hit_mask;

  //--------------------------------------------------------------
  // Watch clock tick
  //--------------------------------------------------------------
  // Main source: one tick per 128 oscillator ticks
  wire div_wrap = i_main_osc_tick && (&div_q);
  wire wtick = clock_source_sel ? i_sub_osc_tick : div_wrap;

  always @*
  begin
    div_d = div_q;
    if (i_main_osc_tick)
      div_d = div_q + 1'h1;
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      div_q <= {MAIN_DIV_W{1'h0}};
    else
      div_q <= div_d;
  end

  //--------------------------------------------------------------
  // Prescaler taps: bit k falls every 2^(k+1) watch cycles
  //--------------------------------------------------------------
  wire [PRE_W-1:0] pre_nx = pre_q + 1'h1;
  wire [PRE_W-1:0] pre_fall;
  genvar g;
  generate
    for (g = 0; g < PRE_W; g = g + 1)
    begin : g_tap
      assign pre_fall[g] = wtick && timer_enable && pre_q[g] &&
                           !pre_nx[g];
    end
  endgenerate

  //--------------------------------------------------------------
  // Interval event
  //--------------------------------------------------------------
  wire [3:0] ivl_idx = {1'h0, interval_sel} + `WIT_IVL_BASE;
  wire ivl_evt = pre_fall[ivl_idx];

  //--------------------------------------------------------------
  // Short watch periods straight from prescaler taps
  //--------------------------------------------------------------
  wire tap_short = pre_fall[`WIT_TAP_P5] && counter_run;
  wire tap_tiny = pre_fall[`WIT_TAP_P4] && counter_run;

  //--------------------------------------------------------------
  // Counter stepping
  //--------------------------------------------------------------
  // First tap fall after start only arms the counter
  wire cnt_tap = pre_fall[`WIT_CNT_TAP] && counter_run;
  wire cnt_step = cnt_tap && armed_q;
  wire cnt_ovf = cnt_step && (&cnt_q);
  wire [CNT_W-1:0] cnt_nx = cnt_q + 1'h1;
  wire cnt_mid_fall = cnt_step && cnt_q[CNT_W-2] && !cnt_nx[CNT_W-2];

  always @*
  begin
    armed_d = armed_q;
    if (!timer_enable || !counter_run)
      armed_d = 1'h0;
    else if (cnt_tap)
      armed_d = 1'h1;
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      armed_q <= 1'h0;
    else
      armed_q <= armed_d;
  end

  //--------------------------------------------------------------
  // Watch event
  //--------------------------------------------------------------
  always @*
  begin
    case (period_sel)
      PER_LONG:
      begin
        watch_evt = cnt_ovf;
      end
      PER_MID:
      begin
        watch_evt = cnt_mid_fall;
      end
      PER_SHORT:
      begin
        watch_evt = tap_short;
      end
      PER_TINY:
      begin
        watch_evt = tap_tiny;
      end
      default:
      begin
        watch_evt = 1'h0;
      end
    endcase
  end

  wire watch_fire = watch_evt && timer_enable;

  //--------------------------------------------------------------
  // Chain
  //--------------------------------------------------------------
  always @*
  begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (!timer_enable)
    begin
      pre_d = {PRE_W{1'h0}};
      cnt_d = {CNT_W{1'h0}};
    end
    else
    begin
      if (wtick)
        pre_d = pre_nx;
      if (!counter_run)
        cnt_d = {CNT_W{1'h0}};
      else if (cnt_step)
        cnt_d = cnt_nx;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      pre_q <= {PRE_W{1'h0}};
      cnt_q <= {CNT_W{1'h0}};
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  //--------------------------------------------------------------
  // Mode and mask registers
  //--------------------------------------------------------------
  // A single-bit write arrives as a whole-byte write
  always @*
  begin
    watch_mode_control_d = watch_mode_control_q;
    if (wr_mode)
      watch_mode_control_d = i_wdata;
  end

  always @*
  begin
    mask_d = mask_q;
    if (wr_mask)
      mask_d = i_wdata[N_EVT-1:0];
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      watch_mode_control_q <= `WIT_MODE_RST;
      mask_q <= {N_EVT{1'h0}};
    end
    else
    begin
      watch_mode_control_q <= watch_mode_control_d;
      mask_q <= mask_d;
    end
  end

  //--------------------------------------------------------------
  // Sticky status, one bit per event
  //--------------------------------------------------------------
  wire [N_EVT-1:0] evt_vec;
  wire [N_EVT-1:0] clr_vec;
  wire [N_EVT-1:0] stat_d;
  assign evt_vec[`WIT_STAT_WATCH] = watch_fire;
  assign evt_vec[`WIT_STAT_IVL] = ivl_evt;
  assign clr_vec = wr_stat ? i_wdata[N_EVT-1:0] : {N_EVT{1'h0}};

  genvar e;
  generate
    for (e = 0; e < N_EVT; e = e + 1)
    begin : g_stat
      // Set wins over write-one-to-clear
      assign stat_d[e] = evt_vec[e] || (stat_q[e] && !clr_vec[e]);
    end
  endgenerate

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      stat_q <= {N_EVT{1'h0}};
    else
      stat_q <= stat_d;
  end

  //--------------------------------------------------------------
  // Event pulses and interrupt
  //--------------------------------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_periodic_watch_irq <= 1'h0;
      o_interval_irq <= 1'h0;
    end
    else
    begin
      o_periodic_watch_irq <= watch_fire;
      o_interval_irq <= ivl_evt;
    end
  end

  assign o_irq = |(stat_q & mask_q);

  //--------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------
  always @*
  begin
    rdata_d = 8'h00;
    if (i_rd)
    begin
      if (hit_mode)
        rdata_d = watch_mode_control_q;
      else if (hit_stat)
        rdata_d = {{(8-N_EVT){1'h0}}, stat_q};
      else if (hit_mask)
        rdata_d = {{(8-N_EVT){1'h0}}, mask_q};
      else
        rdata_d = 8'h00;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else
      o_rdata <= rdata_d;
  end

endmodule // wit_watch_timer
`default_nettype wire

// *** rtl/wit_defines.vh ***
// Purpose: Constants for the watch interval timer
// Assumes: 8-bit mode register, plain register port
// Notes: Offsets are word indices on the plain port
`ifndef WIT_DEFINES_VH
`define WIT_DEFINES_VH

`define WIT_ADDR_W 16
`define WIT_MODE_OFS 16'hff6f
`define WIT_STAT_OFS 16'hff70
`define WIT_MASK_OFS 16'hff71
`define WIT_MODE_RST 8'h00
`define WIT_MASK_RST 8'h00

`define WIT_BIT_EN 0
`define WIT_BIT_RUN 1
`define WIT_BIT_PER0 2
`define WIT_BIT_PER1 3
`define WIT_BIT_IVL0 4
`define WIT_BIT_IVL2 6
`define WIT_BIT_CLK 7

`define WIT_STAT_WATCH 0
`define WIT_STAT_IVL 1

`define WIT_PRE_W 11
`define WIT_CNT_W 5
`define WIT_MAIN_DIV_W 7
`define WIT_CNT_TAP 8
`define WIT_IVL_BASE 4'h3
`define WIT_TAP_P5 4
`define WIT_TAP_P4 3

`endif

// *** tb/wit_props.sv ***
// Purpose: Port checks for the watch timer
// Assumes: One clock, reset synchronous
// Notes: Bound from the testbench
`timescale 1ns/1ps
`default_nettype none
module wit_props
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_main_osc_tick,
  input wire logic i_sub_osc_tick,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_periodic_watch_irq,
  input wire logic o_interval_irq,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire tk = i_main_osc_tick | i_sub_osc_tick;
  wire mw = i_wr && i_addr == 16'hff6f;
  wire w = o_periodic_watch_irq;
  wire v = o_interval_irq;
  sequence s_quiet(p);
    ##2 (!p) [*4];
  endsequence
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("stray read data");
  a_ivl_tick: assert property (v |-> $past(tk))
    else $error("interval without tick");
  a_ivl_one: assert property (v |=> !v) else $error("long pulse");
  a_wt_one: assert property (w |=> !w) else $error("long pulse");
  a_wt_tick: assert property (w |-> $past(tk))
    else $error("watch without tick");
  a_en_off: assert property (mw && !i_wdata[0] |=> s_quiet(v | w))
    else $error("pulse after stop");
  a_run_off: assert property (mw && !i_wdata[1] |=> s_quiet(w))
    else $error("watch after run clear");
  a_irq_rise: assert property ($rose(o_irq) |-> v || w || $past(i_wr))
    else $error("irq without cause");
endmodule // wit_props
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the watch timer
// Assumes: Oscillator ticks high every cycle
// Notes: Pulse spacing is compared exactly
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic i_main_osc_tick = 1, i_sub_osc_tick = 1;
  logic [15:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata, r, rm;
  logic o_periodic_watch_irq, o_interval_irq, o_irq;
  int miscompares = 0, n_tests = 0, t1, t2;
  integer seed;
  wit_watch_timer i_dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_main_osc_tick(i_main_osc_tick),
    .i_sub_osc_tick(i_sub_osc_tick),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_periodic_watch_irq(o_periodic_watch_irq),
    .o_interval_irq(o_interval_irq),
    .o_irq(o_irq)
  );
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 r = o_rdata;
  endtask
  task automatic wait_p(input bit w, output int t);
    t = 0;
    do
    begin
      @(posedge i_ref_clk);
      #1 t = t + 1;
    end
    while ((w ? o_periodic_watch_irq : o_interval_irq) !== 1'b1 && t < 40000);
  endtask
  task automatic meas(input logic [7:0] m, input bit w);
    wr(16'hff6f, 8'h00);
    wr(16'hff6f, m);
    wait_p(w, t1);
    wait_p(w, t2);
  endtask
  function automatic logic [15:0] ewatch(input logic [1:0] p);
    return p[1] ? (p[0] ? 16'h0010 : 16'h0020) : (p[0] ? 16'h2000 : 16'h4000);
  endfunction
  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    repeat (90000) @(posedge i_ref_clk);
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    seed = 32'hdb24b65d;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 0;
    rd(16'hff6f);
    chk(r, 8'h00);
    rm = 8'($random(seed));
    wr(16'hff6f, rm);
    rd(16'hff6f);
    chk(r, rm);
    rd(16'h1234);
    chk(r, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      meas({1'b1, 3'(c), 4'h1}, 0);
      chk(16'(t2), 16'h0010 << c);
    end
    meas(8'h01, 0);
    chk(16'(t2), 16'h0800);
    for (int p = 3; p >= 0; p--)
    begin
      meas({4'h8, 2'(p), 2'h3}, 1);
      chk(16'(t2), ewatch(2'(p)));
      if (p < 2)
        chk(16'(t1 > t2 + 500 && t1 < t2 + 524), 16'h0001);
    end
    wr(16'hff6f, 8'h81);
    wait_p(0, t1);
    chk(16'(t1 <= 17), 16'h0001);
    wr(16'hff6f, 8'h87);
    wait_p(1, t1);
    chk(16'(t1 >= 8190 && t1 < 10760), 16'h0001);
    wr(16'hff6f, 8'h00);
    rd(16'hff70);
    chk(r, 8'h03);
    wr(16'hff71, 8'h03);
    chk(o_irq, 1'b1);
    wr(16'hff70, 8'h03);
    chk(o_irq, 1'b0);
    rd(16'hff70);
    chk(r, 8'h00);
    tally_and_finish;
  end
endmodule // testbench
bind wit_watch_timer wit_props i_props (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_main_osc_tick(i_main_osc_tick),
  .i_sub_osc_tick(i_sub_osc_tick),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_periodic_watch_irq(o_periodic_watch_irq),
  .o_interval_irq(o_interval_irq),
  .o_irq(o_irq)
);
`default_nettype wire
